/* File: design/bdl_regs.svh */
`ifndef BDL_REGS_SVH
`define BDL_REGS_SVH

// Reference cycles per debug clock tick
`define BDL_TICK_DIV     8'h04
// Divider phase loaded at frame start, first tick three cycles later
`define BDL_TICK_START   8'h01
// Bit cell, counted in debug ticks from the falling edge
`define BDL_BIT_TICKS    9'h010
`define BDL_HOST_LOW     9'h004
`define BDL_HOST_ZERO    9'h00d
`define BDL_SAMPLE       9'h00a
`define BDL_TX0_END      9'h00d
`define BDL_SPEEDUP_AT   9'h006
// Sync request and response, in debug ticks
`define BDL_SYNC_MIN     9'h080
`define BDL_SYNC_HOST    9'h088
`define BDL_SYNC_DELAY   9'h010
`define BDL_SYNC_LEN     9'h080
`define BDL_SYNC_TIMEOUT 9'h1ff
// Idle gap after a command's last sent bit, in debug ticks
`define BDL_MEM_GAP      9'h010
// Command codes
`define BDL_CMD_BACKGROUND  8'h90
`define BDL_CMD_READ_STATUS 8'he4
`define BDL_CMD_WRITE_CTRL  8'hc4
`define BDL_CMD_READ_BYTE   8'he0
`define BDL_CMD_WRITE_BYTE  8'hc0
// Status byte fields
`define BDL_STAT_ENABLE  7
`define BDL_STAT_ACTIVE  6
`define BDL_STAT_BUSY    5
// Control byte field
`define BDL_CTRL_ENABLE  7

`endif

/* File: design/bdl_pkg.sv */
package bdl_pkg;

   typedef enum logic [2:0] {
      D_IDLE, D_RX, D_TX, D_WAIT_HIGH, D_SYNC_WAIT, D_SYNC_DRIVE, D_SPEEDUP
   } dev_state_e;

   typedef enum logic [1:0] {PH_CMD, PH_ARG, PH_TX} phase_e;

   typedef enum logic [2:0] {
      H_IDLE, H_LOW, H_SPEED, H_REL, H_GAP, H_SLOW, H_SSPEED, H_SWAIT
   } host_state_e;

   typedef struct packed {
      logic [1:0]  sync;
      logic        last;
      logic [7:0]  div;
      logic        tick;
      dev_state_e  st;
      logic [8:0]  cnt;
      phase_e      phase;
      logic [7:0]  cmd;
      logic [23:0] sh;
      logic [4:0]  nbits;
      logic [7:0]  txsh;
      logic        enable;
      logic        active;
      logic        mem_req;
      logic        mem_we;
      logic [15:0] mem_addr;
      logic [7:0]  mem_wdata;
      logic        drv;
      logic        lvl;
   } dev_s;

   typedef struct packed {
      logic [1:0]  sync;
      logic [7:0]  div;
      logic        tick;
      host_state_e st;
      logic        meas;
      logic [8:0]  cnt;
      logic [31:0] osh;
      logic [5:0]  ntx;
      logic [3:0]  nrx;
      logic [7:0]  rsh;
      logic        drv;
      logic        lvl;
      logic        rsp_valid;
      logic [7:0]  rsp_data;
      logic        sync_done;
      logic [15:0] sync_cycles;
   } host_s;

endpackage : bdl_pkg

/* File: design/bdl_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface bdl_link_if;
   logic tgt_o;
   logic tgt_oe;
   logic host_o;
   logic host_oe;
   logic line;

   // Wired line: pulled up when idle, low wins a clash
   assign line = (tgt_oe ? tgt_o : 1'b1) & (host_oe ? host_o : 1'b1);

   modport target (output tgt_o, output tgt_oe, input line);
   modport host   (output host_o, output host_oe, input line);
endinterface : bdl_link_if

`default_nettype wire

/* File: design/bdl_target.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bdl_regs.svh"

module bdl_target (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // Debug line
   bdl_link_if.target       link,
   // Memory access
   output logic             mem_req,
   output logic             mem_we,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  mem_rdata,
   // Core mode
   output logic             bg_active,
   input  wire logic        bg_exit
);

   bdl_pkg::dev_s q;
   bdl_pkg::dev_s d;
   logic          fall;
   logic [23:0]   sh_new;
   logic [7:0]    status;

   // Next state of the whole controller
   always_comb begin
      d      = q;
      fall   = q.last & ~q.sync[1];
      sh_new = {q.sh[22:0], q.sync[1]};
      status = 8'h00;
      status[`BDL_STAT_ENABLE] = q.enable;
      status[`BDL_STAT_ACTIVE] = q.active;
      status[`BDL_STAT_BUSY]   = q.mem_req;

      // Pin synchroniser and edge history
      d.sync = {q.sync[0], link.line};
      d.last = q.sync[1];

      // Debug tick divider
      d.tick = 1'b0;
      if (q.div == `BDL_TICK_DIV - 8'h01) begin
         d.div  = 8'h00;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 8'h01;
      end

      d.drv = 1'b0;
      d.lvl = 1'b0;
      if (bg_exit) begin
         d.active = 1'b0;
      end

      // Memory handshake runs beside the bit engine
      if (q.mem_req && mem_ack) begin
         d.mem_req = 1'b0;
         if (!q.mem_we) begin
            d.txsh  = mem_rdata;
            d.phase = bdl_pkg::PH_TX;
            d.nbits = 5'h08;
         end
      end

      case (q.st)
         bdl_pkg::D_IDLE: begin
            if (fall) begin
               d.cnt = 9'h000;
               d.st  = (q.phase == bdl_pkg::PH_TX) ? bdl_pkg::D_TX : bdl_pkg::D_RX;
            end
         end
         bdl_pkg::D_RX: begin
            if (q.tick) begin
               d.cnt = q.cnt + 9'h001;
            end
            if (q.tick && q.cnt == `BDL_SAMPLE) begin
               d.sh    = sh_new;
               d.nbits = q.nbits - 5'h01;
               d.st    = bdl_pkg::D_WAIT_HIGH;
               if (q.nbits == 5'h01 && q.phase == bdl_pkg::PH_CMD) begin
                  // Command byte complete: decode
                  d.cmd   = sh_new[7:0];
                  d.phase = bdl_pkg::PH_ARG;
                  d.nbits = 5'h08;
                  case (sh_new[7:0])
                     `BDL_CMD_READ_STATUS: begin
                        d.phase = bdl_pkg::PH_TX;
                        d.txsh  = status;
                     end
                     `BDL_CMD_WRITE_CTRL: d.nbits = 5'h08;
                     `BDL_CMD_READ_BYTE:  d.nbits = 5'h10;
                     `BDL_CMD_WRITE_BYTE: d.nbits = 5'h18;
                     `BDL_CMD_BACKGROUND: begin
                        if (q.enable) begin
                           d.active = 1'b1;
                        end
                        d.phase = bdl_pkg::PH_CMD;
                     end
                     default: d.phase = bdl_pkg::PH_CMD;
                  endcase
               end else if (q.nbits == 5'h01) begin
                  // Arguments complete: execute
                  d.phase = bdl_pkg::PH_CMD;
                  d.nbits = 5'h08;
                  case (q.cmd)
                     `BDL_CMD_WRITE_CTRL: d.enable = sh_new[`BDL_CTRL_ENABLE];
                     `BDL_CMD_READ_BYTE: begin
                        d.mem_req  = 1'b1;
                        d.mem_we   = 1'b0;
                        d.mem_addr = sh_new[15:0];
                     end
                     `BDL_CMD_WRITE_BYTE: begin
                        d.mem_req   = 1'b1;
                        d.mem_we    = 1'b1;
                        d.mem_addr  = sh_new[23:8];
                        d.mem_wdata = sh_new[7:0];
                     end
                     default: d.phase = bdl_pkg::PH_CMD;
                  endcase
               end
            end
         end
         bdl_pkg::D_TX: begin
            // Zero: hold low past host release; one: short high kick
            d.lvl = q.txsh[7];
            d.drv = q.txsh[7] ? (q.cnt == `BDL_SPEEDUP_AT)
                              : (q.cnt < `BDL_TX0_END);
            if (q.tick) begin
               d.cnt = q.cnt + 9'h001;
            end
            if (q.tick && q.cnt == `BDL_TX0_END) begin
               d.drv   = 1'b0;
               d.txsh  = {q.txsh[6:0], 1'b0};
               d.nbits = q.nbits - 5'h01;
               d.st    = bdl_pkg::D_WAIT_HIGH;
               if (q.nbits == 5'h01) begin
                  d.phase = bdl_pkg::PH_CMD;
                  d.nbits = 5'h08;
               end
            end
         end
         bdl_pkg::D_WAIT_HIGH: begin
            // A low held this long is a sync request
            if (q.sync[1]) begin
               d.st = bdl_pkg::D_IDLE;
            end else if (q.tick) begin
               d.cnt = q.cnt + 9'h001;
               if (q.cnt == `BDL_SYNC_MIN) begin
                  d.st    = bdl_pkg::D_SYNC_WAIT;
                  d.cnt   = 9'h000;
                  d.phase = bdl_pkg::PH_CMD;
                  d.nbits = 5'h08;
               end
            end
         end
         bdl_pkg::D_SYNC_WAIT: begin
            if (!q.sync[1]) begin
               d.cnt = 9'h000;
            end else if (q.tick) begin
               d.cnt = q.cnt + 9'h001;
               if (q.cnt == `BDL_SYNC_DELAY - 9'h001) begin
                  d.st  = bdl_pkg::D_SYNC_DRIVE;
                  d.cnt = 9'h000;
               end
            end
         end
         bdl_pkg::D_SYNC_DRIVE: begin
            d.drv = 1'b1;
            d.lvl = 1'b0;
            if (q.tick) begin
               d.cnt = q.cnt + 9'h001;
               if (q.cnt == `BDL_SYNC_LEN - 9'h001) begin
                  d.st  = bdl_pkg::D_SPEEDUP;
                  d.cnt = 9'h000;
               end
            end
         end
         bdl_pkg::D_SPEEDUP: begin
            d.drv = 1'b1;
            d.lvl = 1'b1;
            if (q.tick) begin
               d.drv = 1'b0;
               d.st  = bdl_pkg::D_IDLE;
            end
         end
         default: d.st = bdl_pkg::D_IDLE;
      endcase

      // Reset: strap taken from synchronised pin on every reset cycle
      if (srst) begin
         d        = '0;
         d.st     = bdl_pkg::D_IDLE;
         d.phase  = bdl_pkg::PH_CMD;
         d.nbits  = 5'h08;
         d.sync   = {q.sync[0], link.line};
         d.last   = q.sync[1];                             // No false edge at release
         d.active = ~q.sync[1];
         d.enable = ~q.sync[1];
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      q <= d;
   end

   // Outputs straight from the state register
   assign link.tgt_o  = q.lvl;
   assign link.tgt_oe = q.drv;
   assign mem_req     = q.mem_req;
   assign mem_we      = q.mem_we;
   assign mem_addr    = q.mem_addr;
   assign mem_wdata   = q.mem_wdata;
   assign bg_active   = q.active;

endmodule : bdl_target

`default_nettype wire

/* File: design/bdl_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bdl_regs.svh"

module bdl_host (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // Debug line
   bdl_link_if.host         link,
   // Command request
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [7:0]  req_cmd,
   input  wire logic [15:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   // Command answer
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   // Rate measurement
   input  wire logic        sync_start,
   output logic             sync_done,
   output logic [15:0]      sync_cycles
);

   bdl_pkg::host_s q;
   bdl_pkg::host_s d;
   logic [8:0]     lim;

   // Next state of the host engine
   always_comb begin
      d   = q;
      lim = (q.ntx == 6'h00 || q.osh[31]) ? `BDL_HOST_LOW : `BDL_HOST_ZERO;
      d.sync      = {q.sync[0], link.line};
      d.rsp_valid = 1'b0;
      d.sync_done = 1'b0;
      d.drv       = 1'b0;
      d.lvl       = 1'b0;

      // Tick at the target's debug rate
      d.tick = 1'b0;
      if (q.div == `BDL_TICK_DIV - 8'h01) begin
         d.div  = 8'h00;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 8'h01;
      end
      if (q.tick) begin
         d.cnt = q.cnt + 9'h001;
      end

      case (q.st)
         bdl_pkg::H_IDLE: begin
            d.cnt = 9'h000;
            // Restart the divider so the first low lasts whole ticks
            if (sync_start || req_valid) begin
               d.div  = `BDL_TICK_START;
               d.tick = 1'b0;
            end
            if (sync_start) begin
               d.st = bdl_pkg::H_SLOW;
            end else if (req_valid) begin
               d.st  = bdl_pkg::H_LOW;
               d.nrx = 4'h0;
               case (req_cmd)
                  `BDL_CMD_READ_STATUS: begin
                     d.osh = {req_cmd, 24'h000000};
                     d.ntx = 6'h08;
                     d.nrx = 4'h8;
                  end
                  `BDL_CMD_WRITE_CTRL: begin
                     d.osh = {req_cmd, req_wdata, 16'h0000};
                     d.ntx = 6'h10;
                  end
                  `BDL_CMD_READ_BYTE: begin
                     d.osh = {req_cmd, req_addr, 8'h00};
                     d.ntx = 6'h18;
                     d.nrx = 4'h8;
                  end
                  `BDL_CMD_WRITE_BYTE: begin
                     d.osh = {req_cmd, req_addr, req_wdata};
                     d.ntx = 6'h20;
                  end
                  default: begin
                     d.osh = {req_cmd, 24'h000000};
                     d.ntx = 6'h08;
                  end
               endcase
            end
         end
         bdl_pkg::H_LOW: begin
            d.drv = 1'b1;
            if (q.cnt == lim) begin
               d.drv = (q.ntx != 6'h00);
               d.lvl = 1'b1;
               d.st  = (q.ntx != 6'h00) ? bdl_pkg::H_SPEED : bdl_pkg::H_REL;
            end
         end
         bdl_pkg::H_SPEED: begin
            d.drv = 1'b1;
            d.lvl = 1'b1;
            if (q.tick) begin
               d.drv = 1'b0;
               d.st  = bdl_pkg::H_REL;
            end
         end
         bdl_pkg::H_REL: begin
            if (q.tick && q.ntx == 6'h00 && q.cnt == `BDL_SAMPLE) begin
               d.rsh = {q.rsh[6:0], q.sync[1]};
            end
            if (q.tick && q.cnt == `BDL_BIT_TICKS - 9'h001) begin
               d.cnt = 9'h000;
               if (q.ntx != 6'h00) begin
                  d.osh = {q.osh[30:0], 1'b0};
                  d.ntx = q.ntx - 6'h01;
                  d.st  = (q.ntx == 6'h01) ? bdl_pkg::H_GAP : bdl_pkg::H_LOW;
               end else begin
                  d.nrx = q.nrx - 4'h1;
                  d.st  = (q.nrx == 4'h1) ? bdl_pkg::H_IDLE : bdl_pkg::H_LOW;
                  if (q.nrx == 4'h1) begin
                     d.rsp_valid = 1'b1;
                     d.rsp_data  = q.rsh;
                  end
               end
            end
         end
         bdl_pkg::H_GAP: begin
            // Room for the target's memory access, ended on a tick
            if (q.tick && q.cnt == `BDL_MEM_GAP - 9'h001) begin
               d.cnt = 9'h000;
               if (q.nrx != 4'h0) begin
                  d.st = bdl_pkg::H_LOW;
               end else begin
                  d.st        = bdl_pkg::H_IDLE;
                  d.rsp_valid = 1'b1;
                  d.rsp_data  = 8'h00;
               end
            end
         end
         bdl_pkg::H_SLOW: begin
            d.drv = 1'b1;
            if (q.cnt == `BDL_SYNC_HOST) begin
               d.lvl = 1'b1;
               d.st  = bdl_pkg::H_SSPEED;
            end
         end
         bdl_pkg::H_SSPEED: begin
            d.drv = 1'b1;
            d.lvl = 1'b1;
            if (q.tick) begin
               d.drv  = 1'b0;
               d.cnt  = 9'h000;
               d.meas = 1'b0;
               d.st   = bdl_pkg::H_SWAIT;
            end
         end
         bdl_pkg::H_SWAIT: begin
            // Measure the answer pulse in reference cycles
            if (!q.sync[1]) begin
               if (!q.meas) begin
                  d.sync_cycles = 16'h0001;                // First low cycle counts
               end else if (q.sync_cycles != 16'hffff) begin
                  d.sync_cycles = q.sync_cycles + 16'h0001;
               end
               d.meas = 1'b1;
            end else if (q.meas || q.cnt == `BDL_SYNC_TIMEOUT) begin
               if (!q.meas) begin
                  d.sync_cycles = 16'h0000;
               end
               d.sync_done = 1'b1;
               d.st        = bdl_pkg::H_IDLE;
            end
         end
         default: d.st = bdl_pkg::H_IDLE;
      endcase

      if (srst) begin
         d      = '0;
         d.st   = bdl_pkg::H_IDLE;
         d.sync = {q.sync[0], link.line};
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      q <= d;
   end

   // Outputs
   assign req_ready    = (q.st == bdl_pkg::H_IDLE) & ~sync_start & ~srst;
   assign link.host_o  = q.lvl;
   assign link.host_oe = q.drv;
   assign rsp_valid    = q.rsp_valid;
   assign rsp_data     = q.rsp_data;
   assign sync_done    = q.sync_done;
   assign sync_cycles  = q.sync_cycles;

endmodule : bdl_host

`default_nettype wire

/* File: verification/bdl_link_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module bdl_link_assertions (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // Drives and level of the shared wire
   input  wire logic tgt_o,
   input  wire logic tgt_oe,
   input  wire logic host_o,
   input  wire logic host_oe,
   input  wire logic line
);
   logic       hl;
   logic       tl;
   logic       hh;
   logic       th;
   logic [9:0] hl_cnt_q;
   logic [9:0] tl_cnt_q;
   logic [9:0] hi_cnt_q;

   // Who pulls the wire low or pushes it high
   assign hl = host_oe & ~host_o;
   assign tl = tgt_oe & ~tgt_o;
   assign hh = host_oe & host_o;
   assign th = tgt_oe & tgt_o;

   // Run lengths of each low drive and of a high wire
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hl_cnt_q <= 10'h000;
         tl_cnt_q <= 10'h000;
         hi_cnt_q <= 10'h000;
      end else begin
         hl_cnt_q <= hl ? hl_cnt_q + 10'h001 : 10'h000;
         tl_cnt_q <= tl ? tl_cnt_q + 10'h001 : 10'h000;
         hi_cnt_q <= !line ? 10'h000 : (&hi_cnt_q) ? hi_cnt_q : hi_cnt_q + 10'h001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_reset_quiet: assert property ($past(srst) |-> !tgt_oe && !host_oe)
      else $error("wire driven right after reset");
   a_pullup_idle: assert property (!tgt_oe && !host_oe |-> line)
      else $error("released wire not high");
   a_low_wins: assert property (tl || hl |-> !line)
      else $error("driven low but wire high");
   a_no_clash: assert property (tgt_oe && host_oe |-> tgt_o == host_o)
      else $error("both ends drive opposite levels");
   a_host_speedup_len: assert property (hh [*4] |=> !hh)
      else $error("host high pulse longer than one tick");
   a_tgt_speedup_len: assert property (th [*4] |=> !th)
      else $error("target high pulse longer than one tick");
   a_host_low_len: assert property ($fell(hl) |-> hl_cnt_q inside {10'h010, 10'h034, 10'h220})
      else $error("host low time not a bit or sync length");
   a_target_follows: assert property ($rose(tl) |-> hl || hi_cnt_q >= 10'h03c)
      else $error("target pulled wire low on its own");
   a_sync_pulse_len: assert property ($fell(tl) && tl_cnt_q > 10'h064 |-> tl_cnt_q == 10'h200)
      else $error("sync answer pulse has wrong length");
   a_sync_speedup: assert property ($fell(tl) && tl_cnt_q == 10'h200 |-> th)
      else $error("sync answer not ended by high pulse");
endmodule : bdl_link_assertions

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        ref_clk;
   logic        srst;
   logic        mem_req;
   logic        mem_we;
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic        mem_ack;
   logic [7:0]  mem_rdata;
   logic        ack_gap;
   logic [7:0]  mem_arr [0:65535];
   logic        bg_active;
   logic        bg_exit;
   logic        bg_active_b;
   logic        bg_exit_b;
   logic        req_valid;
   logic        req_ready;
   logic [7:0]  req_cmd;
   logic [15:0] req_addr;
   logic [7:0]  req_wdata;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic        sync_start;
   logic        sync_done;
   logic [15:0] sync_cycles;
   int          err_total;
   int          total_checks;
   int          cyc;

   bdl_link_if link();
   bdl_link_if link_b();

   bdl_target i_bdl_target (.ref_clk(ref_clk), .srst(srst), .link(link),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bg_active(bg_active), .bg_exit(bg_exit));

   // Second target whose wire the bench holds low in reset
   bdl_target i_bdl_target_2 (.ref_clk(ref_clk), .srst(srst), .link(link_b),
      .mem_req(), .mem_we(), .mem_addr(), .mem_wdata(),
      .mem_ack(1'b0), .mem_rdata(8'h00), .bg_active(bg_active_b), .bg_exit(bg_exit_b));

   bdl_host i_bdl_host (.ref_clk(ref_clk), .srst(srst), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .sync_start(sync_start), .sync_done(sync_done),
      .sync_cycles(sync_cycles));

   bdl_link_assertions i_bdl_link_assertions (.ref_clk(ref_clk), .srst(srst),
      .tgt_o(link.tgt_o), .tgt_oe(link.tgt_oe), .host_o(link.host_o),
      .host_oe(link.host_oe), .line(link.line));

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Memory acks a request in the same cycle, then skips one cycle
   always @(posedge ref_clk) begin
      #1;
      if (mem_ack) begin
         mem_ack = 1'b0;
         ack_gap = 1'b1;
      end else if (ack_gap) begin
         ack_gap = 1'b0;
      end else if (mem_req === 1'b1) begin
         if (mem_we === 1'b1) mem_arr[mem_addr] = mem_wdata;
         mem_rdata = mem_arr[mem_addr];
         mem_ack = 1'b1;
      end
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         end_sim();
      end
   end

   task check(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One command through the host, answer compared
   task run_cmd(input logic [7:0] cmd, input logic [15:0] addr, input logic [7:0] wd,
                input logic [7:0] exp);
      int n;
      @(posedge ref_clk);
      #1;
      req_valid = 1'b1;
      req_cmd = cmd;
      req_addr = addr;
      req_wdata = wd;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
      check("rsp_data", {8'h00, exp}, {8'h00, rsp_data});
   endtask : run_cmd

   task end_sim;
      if (err_total == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      int n;
      srst = 1'b1;
      req_valid = 1'b0;
      req_cmd = 8'h00;
      req_addr = 16'h0000;
      req_wdata = 8'h00;
      sync_start = 1'b0;
      bg_exit = 1'b0;
      bg_exit_b = 1'b0;
      mem_ack = 1'b0;
      mem_rdata = 8'h00;
      ack_gap = 1'b0;
      err_total = 0;
      total_checks = 0;
      cyc = 0;
      link_b.host_o = 1'b0;
      link_b.host_oe = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      link_b.host_oe = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check("bg_active", 16'h0000, {15'h0000, bg_active});
      check("bg_active_b", 16'h0001, {15'h0000, bg_active_b});
      bg_exit_b = 1'b1;
      @(posedge ref_clk);
      #1;
      bg_exit_b = 1'b0;
      check("bg_active_b", 16'h0000, {15'h0000, bg_active_b});
      run_cmd(8'he4, 16'h0000, 8'h00, 8'h00);
      run_cmd(8'h90, 16'h0000, 8'h00, 8'h00);
      run_cmd(8'he4, 16'h0000, 8'h00, 8'h00);
      run_cmd(8'hc4, 16'h0000, 8'h80, 8'h00);
      run_cmd(8'he4, 16'h0000, 8'h00, 8'h80);
      run_cmd(8'h90, 16'h0000, 8'h00, 8'h00);
      check("bg_active", 16'h0001, {15'h0000, bg_active});
      run_cmd(8'he4, 16'h0000, 8'h00, 8'hc0);
      @(posedge ref_clk);
      #1;
      bg_exit = 1'b1;
      @(posedge ref_clk);
      #1;
      bg_exit = 1'b0;
      run_cmd(8'h11, 16'h0000, 8'h00, 8'h00);
      run_cmd(8'he4, 16'h0000, 8'h00, 8'h80);
      run_cmd(8'hc0, 16'h12c5, 8'hc5, 8'h00);
      check("mem_arr", 16'h00c5, {8'h00, mem_arr[16'h12c5]});
      run_cmd(8'he0, 16'h12c5, 8'h00, 8'hc5);
      // Rate measurement through a sync request
      @(posedge ref_clk);
      #1;
      sync_start = 1'b1;
      @(posedge ref_clk);
      #1;
      sync_start = 1'b0;
      n = 0;
      while (sync_done !== 1'b1 && n < 4000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("sync_done", 16'h0001, {15'h0000, sync_done});
      check("sync_cycles", 16'h0200, sync_cycles);
      run_cmd(8'he4, 16'h0000, 8'h00, 8'h80);
      end_sim();
   end
endmodule : testbench

`default_nettype wire
